//--- verilog/cbu_pkg.sv
// Purpose: Shared constants for the conditional branch unit.
// Assumes: 8-bit opcodes, 8-bit signed offsets, 32-bit register bus.
// Notes:   Register offsets are byte addresses on the AXI4-Lite bus.

// ==========================================================================
// Package
package cbu_pkg;

  // Branch opcodes, one byte each.
  localparam logic [7:0] OPC_BRANCH_ALWAYS               = 8'h20;
  localparam logic [7:0] OPC_BRANCH_NEVER                = 8'h21;
  localparam logic [7:0] OPC_BRANCH_UNSIGNED_HIGHER      = 8'h22;
  localparam logic [7:0] OPC_BRANCH_UNSIGNED_LOWER_SAME  = 8'h23;
  localparam logic [7:0] OPC_BRANCH_UNSIGNED_HIGHER_SAME = 8'h24;
  localparam logic [7:0] OPC_BRANCH_CARRY_CLEAR          =
    OPC_BRANCH_UNSIGNED_HIGHER_SAME;
  localparam logic [7:0] OPC_BRANCH_UNSIGNED_LOWER       = 8'h25;
  localparam logic [7:0] OPC_BRANCH_NOT_EQUAL            = 8'h26;
  localparam logic [7:0] OPC_BRANCH_EQUAL                = 8'h27;
  localparam logic [7:0] OPC_BRANCH_OVF_CLEAR            = 8'h28;
  localparam logic [7:0] OPC_BRANCH_OVF_SET              = 8'h29;
  localparam logic [7:0] OPC_BRANCH_PLUS                 = 8'h2a;
  localparam logic [7:0] OPC_BRANCH_MINUS                = 8'h2b;
  localparam logic [7:0] OPC_BRANCH_SIGNED_GREATER_EQUAL = 8'h2c;
  localparam logic [7:0] OPC_BRANCH_SIGNED_LESS          = 8'h2d;
  localparam logic [7:0] OPC_BRANCH_SIGNED_GREATER       = 8'h2e;
  localparam logic [7:0] OPC_BRANCH_SIGNED_LESS_EQUAL    = 8'h2f;

  // Target is the branch address plus this step plus the offset.
  localparam logic [15:0] PC_STEP = 16'h0002;

  // Program fetch cycles for a taken and a fall-through branch.
  localparam logic [1:0] FETCH_TAKEN     = 2'h3;
  localparam logic [1:0] FETCH_NOT_TAKEN = 2'h1;

  // Flag positions inside the condition snapshot.
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;

  // Register byte offsets.
  localparam int         ADDR_W         = 8;
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_TAKEN_CNT = 8'h08;
  localparam logic [7:0] ADDR_FALL_CNT  = 8'h0c;
  localparam logic [7:0] ADDR_TARGET    = 8'h10;

  // Control and status fields.
  localparam int   CTRL_ENABLE_BIT   = 0;
  localparam int   CTRL_CLEAR_BIT    = 1;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int   STAT_BUSY_BIT     = 0;
  localparam int   STAT_TAKEN_BIT    = 1;
  localparam int   STAT_BAD_BIT      = 2;
  localparam int   STAT_OPC_LSB      = 8;
  localparam int   STAT_FLAGS_LSB    = 16;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FETCH = 2'b10
  } cbu_state_t;

endpackage

//--- verilog/cbu_cond_eval.sv
// Purpose: Decodes a branch opcode and tests the condition flags.
// Assumes: Flags are those left by the previous flag-setting instruction.
// Notes:   Purely combinational; never writes any flag.

`timescale 1ns/1ps

// ==========================================================================
// Condition evaluator
module cbu_cond_eval (
  // Instruction and flags
  input  wire logic [7:0] opcode,
  input  wire logic [3:0] flags,
  // Decision
  output logic            isBranch,
  output logic            takeIt
);

  logic n;
  logic z;
  logic v;
  logic c;

  assign n = flags[cbu_pkg::FLAG_N];
  assign z = flags[cbu_pkg::FLAG_Z];
  assign v = flags[cbu_pkg::FLAG_V];
  assign c = flags[cbu_pkg::FLAG_C];

  // Each test is paired with its complement on the neighbouring opcode.
  always_comb
  begin
    isBranch = 1'b1;
    takeIt   = 1'b0;
    unique case (opcode)
      cbu_pkg::OPC_BRANCH_ALWAYS:               takeIt = 1'b1;
      cbu_pkg::OPC_BRANCH_NEVER:                takeIt = 1'b0;
      cbu_pkg::OPC_BRANCH_UNSIGNED_HIGHER:      takeIt = ~(c | z);
      cbu_pkg::OPC_BRANCH_UNSIGNED_LOWER_SAME:  takeIt = c | z;
      cbu_pkg::OPC_BRANCH_UNSIGNED_HIGHER_SAME: takeIt = ~c;
      cbu_pkg::OPC_BRANCH_UNSIGNED_LOWER:       takeIt = c;
      cbu_pkg::OPC_BRANCH_NOT_EQUAL:            takeIt = ~z;
      cbu_pkg::OPC_BRANCH_EQUAL:                takeIt = z;
      cbu_pkg::OPC_BRANCH_OVF_CLEAR:            takeIt = ~v;
      cbu_pkg::OPC_BRANCH_OVF_SET:              takeIt = v;
      cbu_pkg::OPC_BRANCH_PLUS:                 takeIt = ~n;
      cbu_pkg::OPC_BRANCH_MINUS:                takeIt = n;
      cbu_pkg::OPC_BRANCH_SIGNED_GREATER_EQUAL: takeIt = ~(n ^ v);
      cbu_pkg::OPC_BRANCH_SIGNED_LESS:          takeIt = n ^ v;
      cbu_pkg::OPC_BRANCH_SIGNED_GREATER:       takeIt = ~(z | (n ^ v));
      cbu_pkg::OPC_BRANCH_SIGNED_LESS_EQUAL:    takeIt = z | (n ^ v);
      default:                                  isBranch = 1'b0;
    endcase
  end

endmodule

//--- verilog/cbu_target_adder.sv
// Purpose: Forms the branch target from address and signed byte offset.
// Assumes: The address is that of the branch opcode itself.
// Notes:   Wraps modulo the program counter width.

`timescale 1ns/1ps

// ==========================================================================
// Target adder
module cbu_target_adder #(
  parameter int PC_W = 16
) (
  // Operands
  input  wire logic [PC_W-1:0] branchPc,
  input  wire logic [7:0]      signedByteOffset,
  // Result
  output logic [PC_W-1:0]      target
);

  assign target = branchPc + PC_W'(cbu_pkg::PC_STEP)
                + {{(PC_W-8){signedByteOffset[7]}}, signedByteOffset};

endmodule

//--- verilog/cbu_branch_unit.sv
// Purpose: Conditional branch unit with fetch sequencing and registers.
// Assumes: Issue inputs and flags are synchronous to ref_clk (40 MHz).
// Notes:   Registers sit on an AXI4-Lite slave; the unit never writes flags.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.

`timescale 1ns/1ps

// ==========================================================================
module cbu_branch_unit #(
  parameter int PC_W  = 16,
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // Instruction issue
  input  wire logic              issueValid,
  output logic                   issueReady,
  input  wire logic [7:0]        issueOpcode,
  input  wire logic [7:0]        issueOffset,
  input  wire logic [PC_W-1:0]   issuePc,
  // Condition flags
  input  wire logic              flagNeg,
  input  wire logic              flagZero,
  input  wire logic              flagOvf,
  input  wire logic              flagCarry,
  // Program counter and fetch
  output logic                   pcLoad,
  output logic [PC_W-1:0]        pcTarget,
  output logic                   progFetch,
  // Result
  output logic                   branchDone,
  output logic                   branchTaken,
  output logic                   badOpcode,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ========================================================================
  // Parameter checks
  if (PC_W < 9 || PC_W > 32) begin : gBadPc
    $error("PC_W must lie between 9 and 32");
  end
  if (CNT_W < 1 || CNT_W > 32) begin : gBadCnt
    $error("CNT_W must lie between 1 and 32");
  end

  // ========================================================================
  // Reset synchroniser
  logic rstMeta_r;
  logic rstnSync;

  // Release is synchronised; assertion stays asynchronous.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta_r <= 1'b0;
      rstnSync  <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstnSync  <= rstMeta_r;
    end
  end

  // ========================================================================
  // Decode and target
  logic [3:0]      flagsIn;
  logic            isBranch;
  logic            takeIt;
  logic [PC_W-1:0] targetCalc;
  logic            issueAcc;

  assign flagsIn = {flagNeg, flagZero, flagOvf, flagCarry};

  cbu_cond_eval uEval (
    .opcode   (issueOpcode),
    .flags    (flagsIn),
    .isBranch (isBranch),
    .takeIt   (takeIt)
  );

  cbu_target_adder #(.PC_W(PC_W)) uAdder (
    .branchPc         (issuePc),
    .signedByteOffset (issueOffset),
    .target           (targetCalc)
  );

  // ========================================================================
  // Sequencer
  cbu_pkg::cbu_state_t state_r;
  cbu_pkg::cbu_state_t state_nxt;
  logic [1:0]          fetchCnt_r;
  logic [1:0]          fetchCnt_nxt;
  logic                taken_r;
  logic                taken_nxt;
  logic [PC_W-1:0]     target_r;
  logic [PC_W-1:0]     target_nxt;
  logic                pcLoad_r;
  logic                pcLoad_nxt;
  logic                bad_r;
  logic                bad_nxt;
  logic                lastBad_r;
  logic                lastBad_nxt;
  logic [7:0]          opc_r;
  logic [7:0]          opc_nxt;
  logic [3:0]          flagsSnap_r;
  logic [3:0]          flagsSnap_nxt;
  logic                ctrlEnable_r;

  // A new branch is taken only while idle, enabled and out of reset;
  // an accept during reset would be lost in the held registers.
  assign issueReady = (state_r == cbu_pkg::ST_IDLE) && ctrlEnable_r
                   && rstnSync;
  assign issueAcc   = issueValid && issueReady;
  assign progFetch  = (state_r == cbu_pkg::ST_FETCH);
  assign branchDone = progFetch && (fetchCnt_r == 2'h1);
  assign pcLoad     = pcLoad_r;
  assign pcTarget   = target_r;
  assign branchTaken = taken_r;
  assign badOpcode  = bad_r;

  // Next values of the sequencer; flags are only sampled, never driven.
  always_comb
  begin
    state_nxt     = state_r;
    fetchCnt_nxt  = fetchCnt_r;
    taken_nxt     = taken_r;
    target_nxt    = target_r;
    pcLoad_nxt    = 1'b0;
    bad_nxt       = 1'b0;
    lastBad_nxt   = lastBad_r;
    opc_nxt       = opc_r;
    flagsSnap_nxt = flagsSnap_r;
    unique case (state_r)
      cbu_pkg::ST_IDLE:
      begin
        if (issueAcc)
        begin
          opc_nxt       = issueOpcode;
          flagsSnap_nxt = flagsIn;
          lastBad_nxt   = !isBranch;
          if (!isBranch)
          begin
            // Unknown opcodes get no fetch and a one-cycle fault pulse.
            bad_nxt   = 1'b1;
            taken_nxt = 1'b0;
          end
          else
          begin
            taken_nxt    = takeIt;
            fetchCnt_nxt = takeIt ? cbu_pkg::FETCH_TAKEN
                                  : cbu_pkg::FETCH_NOT_TAKEN;
            pcLoad_nxt   = takeIt;
            target_nxt   = takeIt ? targetCalc : target_r;
            state_nxt    = cbu_pkg::ST_FETCH;
          end
        end
      end
      cbu_pkg::ST_FETCH:
      begin
        fetchCnt_nxt = fetchCnt_r - 2'h1;
        if (fetchCnt_r == 2'h1)
        begin
          state_nxt = cbu_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = cbu_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge ref_clk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      state_r     <= cbu_pkg::ST_IDLE;
      fetchCnt_r  <= 2'h0;
      taken_r     <= 1'b0;
      target_r    <= '0;
      pcLoad_r    <= 1'b0;
      bad_r       <= 1'b0;
      lastBad_r   <= 1'b0;
      opc_r       <= 8'h00;
      flagsSnap_r <= 4'h0;
    end
    else
    begin
      state_r     <= state_nxt;
      fetchCnt_r  <= fetchCnt_nxt;
      taken_r     <= taken_nxt;
      target_r    <= target_nxt;
      pcLoad_r    <= pcLoad_nxt;
      bad_r       <= bad_nxt;
      lastBad_r   <= lastBad_nxt;
      opc_r       <= opc_nxt;
      flagsSnap_r <= flagsSnap_nxt;
    end
  end

  // ========================================================================
  // Register bus
  logic             ctrlEnable_nxt;
  logic [CNT_W-1:0] takenCnt_r;
  logic [CNT_W-1:0] takenCnt_nxt;
  logic [CNT_W-1:0] fallCnt_r;
  logic [CNT_W-1:0] fallCnt_nxt;
  logic             bvalid_r;
  logic             bvalid_nxt;
  logic [1:0]       bresp_r;
  logic [1:0]       bresp_nxt;
  logic             rvalid_r;
  logic             rvalid_nxt;
  logic [1:0]       rresp_r;
  logic [1:0]       rresp_nxt;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  logic             wrAcc;
  logic             rdAcc;
  logic             ctrlWr;
  logic [31:0]      statusWord;

  // Decodes a byte address into the register map.
  function automatic logic isMapped(input logic [7:0] a);
    return (a == cbu_pkg::ADDR_CTRL) || (a == cbu_pkg::ADDR_STATUS)
        || (a == cbu_pkg::ADDR_TAKEN_CNT) || (a == cbu_pkg::ADDR_FALL_CNT)
        || (a == cbu_pkg::ADDR_TARGET);
  endfunction

  // Address and data are taken together, which the bus allows either way.
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = !rvalid_r;
  assign wrAcc  = s_axi_awready;
  assign rdAcc  = s_axi_arvalid && s_axi_arready;
  assign ctrlWr = wrAcc && s_axi_wstrb[0]
               && (s_axi_awaddr == cbu_pkg::ADDR_CTRL);
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  // Status word shows the last decision and the sampled flags.
  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[cbu_pkg::STAT_BUSY_BIT]  = progFetch;
    statusWord[cbu_pkg::STAT_TAKEN_BIT] = taken_r;
    statusWord[cbu_pkg::STAT_BAD_BIT]   = lastBad_r;
    statusWord[cbu_pkg::STAT_OPC_LSB +: 8]   = opc_r;
    statusWord[cbu_pkg::STAT_FLAGS_LSB +: 4] = flagsSnap_r;
  end

  // Next values of the bus side; an increment in a clear cycle survives.
  always_comb
  begin
    ctrlEnable_nxt = ctrlEnable_r;
    takenCnt_nxt   = takenCnt_r;
    fallCnt_nxt    = fallCnt_r;
    bvalid_nxt     = bvalid_r && !s_axi_bready;
    bresp_nxt      = bresp_r;
    rvalid_nxt     = rvalid_r && !s_axi_rready;
    rresp_nxt      = rresp_r;
    rdata_nxt      = rdata_r;
    if (ctrlWr)
    begin
      ctrlEnable_nxt = s_axi_wdata[cbu_pkg::CTRL_ENABLE_BIT];
      if (s_axi_wdata[cbu_pkg::CTRL_CLEAR_BIT])
      begin
        takenCnt_nxt = '0;
        fallCnt_nxt  = '0;
      end
    end
    if (issueAcc && isBranch && takeIt)
    begin
      takenCnt_nxt = takenCnt_nxt + CNT_W'(1);
    end
    if (issueAcc && isBranch && !takeIt)
    begin
      fallCnt_nxt = fallCnt_nxt + CNT_W'(1);
    end
    if (wrAcc)
    begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = isMapped(s_axi_awaddr) ? cbu_pkg::RESP_OKAY
                                          : cbu_pkg::RESP_DECERR;
    end
    if (rdAcc)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = isMapped(s_axi_araddr) ? cbu_pkg::RESP_OKAY
                                          : cbu_pkg::RESP_DECERR;
      unique case (s_axi_araddr)
        cbu_pkg::ADDR_CTRL:      rdata_nxt = {31'h0, ctrlEnable_r};
        cbu_pkg::ADDR_STATUS:    rdata_nxt = statusWord;
        cbu_pkg::ADDR_TAKEN_CNT: rdata_nxt = 32'(takenCnt_r);
        cbu_pkg::ADDR_FALL_CNT:  rdata_nxt = 32'(fallCnt_r);
        cbu_pkg::ADDR_TARGET:    rdata_nxt = 32'(target_r);
        default:                 rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Bus-side registers.
  always_ff @(posedge ref_clk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      ctrlEnable_r <= cbu_pkg::CTRL_ENABLE_RESET;
      takenCnt_r   <= '0;
      fallCnt_r    <= '0;
      bvalid_r     <= 1'b0;
      bresp_r      <= cbu_pkg::RESP_OKAY;
      rvalid_r     <= 1'b0;
      rresp_r      <= cbu_pkg::RESP_OKAY;
      rdata_r      <= 32'h0000_0000;
    end
    else
    begin
      ctrlEnable_r <= ctrlEnable_nxt;
      takenCnt_r   <= takenCnt_nxt;
      fallCnt_r    <= fallCnt_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rresp_r      <= rresp_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  // ========================================================================
  // Checks on decisions and fetch timing
  AST_HIGHER_DECIDE:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      issueAcc && issueOpcode == cbu_pkg::OPC_BRANCH_UNSIGNED_HIGHER
      |=> branchTaken == !($past(flagCarry) || $past(flagZero)))
    else $error("higher branch decision wrong");

  AST_TARGET_LOAD:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      issueAcc && isBranch && takeIt
      |=> pcLoad && pcTarget == $past(issuePc) + PC_W'(cbu_pkg::PC_STEP)
          + PC_W'($signed($past(issueOffset))))
    else $error("branch target or load wrong");

  AST_CARRY_CLEAR:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      issueAcc && issueOpcode == cbu_pkg::OPC_BRANCH_CARRY_CLEAR
      |=> branchTaken == !$past(flagCarry))
    else $error("higher-or-same decision wrong");

  AST_CARRY_SET:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      issueAcc && issueOpcode == cbu_pkg::OPC_BRANCH_UNSIGNED_LOWER
      |=> branchTaken == $past(flagCarry))
    else $error("lower decision wrong");

  AST_TAKEN_FETCH:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      issueAcc && isBranch && takeIt
      |=> progFetch [*3] ##1 !progFetch)
    else $error("taken branch fetch count not three");

  AST_FALL_FETCH:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      issueAcc && isBranch && !takeIt
      |=> (progFetch && branchDone && !pcLoad) ##1 !progFetch)
    else $error("fall-through fetch count not one");

  AST_SIGNED_GREATER:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      issueAcc && issueOpcode == cbu_pkg::OPC_BRANCH_SIGNED_GREATER
      |=> branchTaken == !($past(flagZero)
          || ($past(flagNeg) ^ $past(flagOvf))))
    else $error("signed greater decision wrong");

  AST_SIGNED_LESS_EQUAL:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      issueAcc && issueOpcode == cbu_pkg::OPC_BRANCH_SIGNED_LESS_EQUAL
      |=> branchTaken == ($past(flagZero)
          || ($past(flagNeg) ^ $past(flagOvf))))
    else $error("signed less-or-equal decision wrong");

  AST_SIGNED_ORDER:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      issueAcc && (issueOpcode == cbu_pkg::OPC_BRANCH_SIGNED_LESS
        || issueOpcode == cbu_pkg::OPC_BRANCH_SIGNED_GREATER_EQUAL)
      |=> branchTaken == (($past(flagNeg) ^ $past(flagOvf))
          == (opc_r == cbu_pkg::OPC_BRANCH_SIGNED_LESS)))
    else $error("signed order decision wrong");

  AST_NOT_HIGHER:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      issueAcc && issueOpcode == cbu_pkg::OPC_BRANCH_UNSIGNED_HIGHER
      && (flagCarry || flagZero) |=> !pcLoad ##1 !progFetch)
    else $error("higher branch taken when not greater");

  AST_FLAGS_KEPT:
    assert property (@(posedge ref_clk) disable iff (!rstnSync)
      progFetch && !branchDone |=> $stable(flagsSnap_r))
    else $error("flag snapshot changed during a branch");

endmodule

//--- test/cbu_branch_unit_tb.sv
// Purpose: Self-checking bench for the conditional branch unit.
// Assumes: Default widths; all inputs change right after rising edges.
// Notes:   Expected decisions come from the bench's own flag table.
`timescale 1ns/1ps
// ======================================================================
// Bench
module cbu_branch_unit_tb;
  logic        ref_clk, resetn, issueValid, issueReady, pcLoad, progFetch;
  logic        flagNeg, flagZero, flagOvf, flagCarry, branchDone;
  logic        branchTaken, badOpcode, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  issueOpcode, issueOffset, s_axi_awaddr, s_axi_araddr;
  logic [15:0] issuePc, pcTarget, a, m, d;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] av [5] = '{16'h5, 16'h3, 16'h7, 16'h8000, 16'hffff};
  logic [15:0] mv [5] = '{16'h3, 16'h5, 16'h7, 16'h0001, 16'h0000};
  int          errTotal, cmpCount, nTak, nFall;

  cbu_branch_unit DUT (.*);

  // The 40 MHz core clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmpCount++;
    if (g !== e)
    begin
      errTotal++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus write; address and data are offered together.
  // Ready and valid are sampled before the edge that completes the handshake.
  task automatic axiWr(logic [7:0] ad, logic [31:0] dt);
    logic r;
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do
    begin
      @(negedge ref_clk);
      r = s_axi_awready && s_axi_wready;
      @(posedge ref_clk);
    end
    while (!r);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do
    begin
      @(negedge ref_clk);
      r  = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge ref_clk);
    end
    while (!r);
  endtask

  // One bus read; data and response land in rd and rs.
  task automatic axiRd(logic [7:0] ad);
    logic r;
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(negedge ref_clk);
      r = s_axi_arready;
      @(posedge ref_clk);
    end
    while (!r);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(negedge ref_clk);
      r  = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge ref_clk);
    end
    while (!r);
  endtask

  // Odd opcodes are the complement of the even one below them.
  function automatic logic expTake(logic [7:0] op, logic [3:0] f);
    logic n, z, v, c;
    {n, z, v, c} = f;
    case (op[3:1])
      3'h0:    expTake = 1'b1;
      3'h1:    expTake = !(c | z);
      3'h2:    expTake = !c;
      3'h3:    expTake = !z;
      3'h4:    expTake = !v;
      3'h5:    expTake = !n;
      3'h6:    expTake = !(n ^ v);
      default: expTake = !(z | (n ^ v));
    endcase
    return expTake ^ op[0];
  endfunction

  // Issues one branch, then watches five cycles of fetch traffic.
  task automatic issue(logic [7:0] op, logic [7:0] off, logic [15:0] pc,
                       logic [3:0] f);
    logic        r, e, ok;
    logic [15:0] t;
    int          nf, np, nd, nb;
    issueOpcode <= op;
    issueOffset <= off;
    issuePc     <= pc;
    issueValid  <= 1'b1;
    {flagNeg, flagZero, flagOvf, flagCarry} <= f;
    do
    begin
      @(negedge ref_clk);
      r = issueReady;
      @(posedge ref_clk);
    end
    while (!r);
    issueValid <= 1'b0;
    {nf, np, nd, nb} = '0;
    repeat (5)
    begin
      #1;
      nf += progFetch;
      np += pcLoad;
      nd += branchDone;
      nb += badOpcode;
      @(posedge ref_clk);
    end
    // The target wraps at the 16-bit program counter width.
    t  = pc + cbu_pkg::PC_STEP + {{8{off[7]}}, off};
    ok = (op[7:4] == 4'h2);
    e  = ok && expTake(op, f);
    nTak  += e;
    nFall += ok && !e;
    chk("taken", e, branchTaken);
    chk("fetch cycles", e ? 3 : ok, nf);
    chk("done pulses", ok, nd);
    chk("bad pulses", !ok, nb);
    chk("pc loads", e, np);
    if (e)
      chk("target", t, pcTarget);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Cuts a hang short; the tests need under two thousand cycles.
  initial
  begin
    #(25 * 20000);
    errTotal++;
    summarize();
  end

  // Main sequence.
  initial
  begin
    {resetn, issueValid, issueOpcode, issueOffset, issuePc} = '0;
    {flagNeg, flagZero, flagOvf, flagCarry} = '0;
    // Both response channels are always ready to take an answer.
    {s_axi_awvalid, s_axi_wvalid, s_axi_awaddr} = '0;
    {s_axi_arvalid, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    axiRd(cbu_pkg::ADDR_CTRL);
    chk("ctrl reset", 32'h1, rd);
    // Clearing the counters first keeps the expected totals exact.
    axiWr(cbu_pkg::ADDR_CTRL, 32'h3);
    chk("write resp", cbu_pkg::RESP_OKAY, rs);
    axiWr(8'h40, 32'h1);
    chk("unmapped write", cbu_pkg::RESP_DECERR, rs);
    axiRd(8'h40);
    chk("unmapped read", cbu_pkg::RESP_DECERR, rs);
    // Every opcode against every flag set, plus one illegal opcode.
    for (int o = 8'h20; o < 8'h31; o++)
      for (int f = 0; f < 16; f++)
        issue(o[7:0], 8'(f * 17), {o[7:0], f[3:0], 4'hc}, f[3:0]);
    axiRd(cbu_pkg::ADDR_TAKEN_CNT);
    chk("taken count", nTak, rd);
    axiRd(cbu_pkg::ADDR_FALL_CNT);
    chk("fall count", nFall, rd);
    issue(cbu_pkg::OPC_BRANCH_SIGNED_GREATER, 8'h80, 16'h0010, 4'ha);
    axiRd(cbu_pkg::ADDR_STATUS);
    chk("status flags", 32'h2e_00 | 32'ha_0000, rd & 32'hf_ff00);
    axiRd(cbu_pkg::ADDR_TARGET);
    chk("target reg", 32'h0000_ff92, rd);
    // Compare results feed the flags; wrap of the target included.
    for (int i = 0; i < 5; i++)
    begin
      a = av[i];
      m = mv[i];
      d = a - m;
      issue(cbu_pkg::OPC_BRANCH_UNSIGNED_HIGHER, 8'h7f, 16'hffff,
            {d[15], d == 0, (a[15] ^ m[15]) & (a[15] ^ d[15]), a < m});
      chk("higher", a > m, branchTaken);
    end
    axiWr(cbu_pkg::ADDR_CTRL, 32'h0);
    @(negedge ref_clk);
    chk("ready disabled", 1'b0, issueReady);
    axiWr(cbu_pkg::ADDR_CTRL, 32'h1);
    summarize();
  end
endmodule
